// >>> rtl/tli_pkg.sv
// Constants, register map and state type of the two-level interrupt tree
`default_nettype none
package tli_pkg;
	localparam int unsigned NUM_PINS = 15;
	localparam int unsigned ADDR_W   = 8;
	localparam int unsigned DATA_W   = 8;

	// Register addresses
	localparam logic [7:0] ADDR_GROUP_STATUS    = 8'h02;
	localparam logic [7:0] ADDR_GROUP_MASK      = 8'h0e;
	localparam logic [7:0] ADDR_SUPPLY_FLAG     = 8'h04;
	localparam logic [7:0] ADDR_REGFAULT_FLAG   = 8'h05;
	localparam logic [7:0] ADDR_DIE_FLAG        = 8'h06;
	localparam logic [7:0] ADDR_CONV_FLAG       = 8'h07;
	localparam logic [7:0] ADDR_PWRBTN_FLAG     = 8'h08;
	localparam logic [7:0] ADDR_PIN_HI_FLAG     = 8'h0b;
	localparam logic [7:0] ADDR_PIN_LO_FLAG     = 8'h0c;
	localparam logic [7:0] ADDR_SUPPLY_MASK     = 8'h10;
	localparam logic [7:0] ADDR_REGFAULT_MASK   = 8'h11;
	localparam logic [7:0] ADDR_DIE_MASK        = 8'h12;
	localparam logic [7:0] ADDR_CONV_MASK       = 8'h13;
	localparam logic [7:0] ADDR_PIN_HI_MASK     = 8'h19;
	localparam logic [7:0] ADDR_PIN_LO_MASK     = 8'h1a;

	// First-level bit positions
	localparam int unsigned BIT_THERMAL   = 1;
	localparam int unsigned BIT_CONVERTER = 3;
	localparam int unsigned BIT_PIN_EVENT = 5;
	localparam int unsigned BIT_REGULATOR = 6;
	localparam logic [7:0]  GROUP_BITS    = 8'h6a;

	// Converter flag register bit positions
	localparam int unsigned CONV_CH0  = 0;
	localparam int unsigned CONV_CH1  = 1;
	localparam int unsigned CONV_CH2  = 2;
	localparam int unsigned CONV_DONE = 3;

	// Pin flag split between high and low byte
	localparam int unsigned PIN_LO_W = 8;
	localparam int unsigned PIN_HI_W = 7;

	// Edge select encoding
	localparam logic [1:0] EDGE_NONE    = 2'h0;
	localparam logic [1:0] EDGE_RISING  = 2'h1;
	localparam logic [1:0] EDGE_FALLING = 2'h2;
	localparam logic [1:0] EDGE_BOTH    = 2'h3;

	// Reset values
	localparam logic [7:0]  RST_GROUP_MASK = 8'h6a;
	localparam logic [7:0]  RST_BYTE_ZERO  = 8'h00;
	localparam logic        RST_BIT_MASKED = 1'b1;
	localparam logic [3:0]  RST_CONV_MASK  = 4'hf;
	localparam logic [14:0] RST_PIN_MASK   = 15'h7fff;

	typedef struct packed {
		logic [NUM_PINS-1:0] pin_prev;
		logic [NUM_PINS-1:0] pin_flag;
		logic [NUM_PINS-1:0] pin_mask;
		logic                supply_flag;
		logic                supply_mask;
		logic                regf_flag;
		logic                regf_mask;
		logic                die_flag;
		logic                die_mask;
		logic [3:0]          conv_flag;
		logic [3:0]          conv_mask;
		logic                notify_armed;
		logic                pwrbtn_flag;
		logic [7:0]          group_mask;
		logic [7:0]          rdata;
	} tli_state_t;
endpackage
`default_nettype wire

// >>> rtl/tli_irq_tree.sv
// Two-level interrupt aggregation unit with byte register port
//
// Operation
// - Unmasked event flag feeds its group bit; power button flag feeds none
// - Pin high while unmasked flags pending
// - Four group status bits, one per sub-block
// - Masked group sets neither status nor pin
// - Group bits clear only via their flags or the group mask
// - Pin drops once group bits clear
// - Regulator 6, pins 5, converter 3, thermal 1
// - Group status at 0x02, resets 0x00
// - Group mask at 0x0E, resets 0x6A
// - Masked event flag never becomes set
// - Flags clear by writing one
// - Supply out-of-range flag, converter group
// - Regulator fault flag, cleared at cold-off
// - Die temperature alert flag, thermal group
// - Three channel alert flags, converter group
// - Conversion done flag needs armed notify
// - Input pin edge raises pin flag
// - Interrupt asserted within one millisecond
`timescale 1ns/1ps
`default_nettype none
module tli_irq_tree
	import tli_pkg::*;
(
	input  wire logic                         clk_sys,
	input  wire logic                         reset_n,
	input  wire logic [tli_pkg::ADDR_W-1:0]   reg_addr,
	input  wire logic [tli_pkg::DATA_W-1:0]   reg_wdata,
	input  wire logic                         reg_wr,
	input  wire logic                         reg_rd,
	output logic      [tli_pkg::DATA_W-1:0]   reg_rdata,
	input  wire logic                         supply_out_of_range,
	input  wire logic                         regulator_fault,
	input  wire logic                         cold_off_entry,
	input  wire logic                         die_temp_alert,
	input  wire logic [2:0]                   voltage_alert,
	input  wire logic                         conv_request,
	input  wire logic                         conv_request_notify,
	input  wire logic                         conv_complete,
	input  wire logic                         power_button_event,
	input  wire logic [tli_pkg::NUM_PINS-1:0] pin_in,
	input  wire logic [tli_pkg::NUM_PINS-1:0] pin_is_input,
	input  wire logic [2*tli_pkg::NUM_PINS-1:0] edge_select_field,
	output logic      [tli_pkg::NUM_PINS-1:0] pin_level,
	output logic                              irq_out
);
	import tli_pkg::*;

	tli_state_t              st_ff;
	tli_state_t              nxt_st;
	logic [NUM_PINS-1:0]     pin_edge;
	logic [NUM_PINS-1:0]     pin_clr;
	logic [3:0]              conv_event;
	logic [7:0]              group_any;
	logic [7:0]              group_status;
	logic [7:0]              rd_mux;
	logic                    wr_supply_flag;
	logic                    wr_regf_flag;
	logic                    wr_die_flag;
	logic                    wr_conv_flag;
	logic                    wr_pwrbtn_flag;
	logic                    wr_pin_hi_flag;
	logic                    wr_pin_lo_flag;
	logic                    supply_set;
	logic                    supply_clr;
	logic                    regf_set;
	logic                    regf_clr;
	logic                    die_set;
	logic                    die_clr;
	logic [3:0]              conv_set;
	logic [3:0]              conv_clr;
	logic                    pwrbtn_clr;
	logic [NUM_PINS-1:0]     pin_set;

	function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] target, input logic wr);
		wr_hit = wr && (a == target);
	endfunction

	// Edge detection per input pin
	genvar gi;
	generate
		for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
			logic [1:0] sel;
			logic       rise;
			logic       fall;
			assign sel  = edge_select_field[2*gi +: 2];
			assign rise = pin_in[gi] & ~st_ff.pin_prev[gi];
			assign fall = ~pin_in[gi] & st_ff.pin_prev[gi];
			assign pin_edge[gi] = pin_is_input[gi] &
				(((sel == EDGE_RISING) | (sel == EDGE_BOTH)) & rise |
				((sel == EDGE_FALLING) | (sel == EDGE_BOTH)) & fall);
		end
	endgenerate

	// Write decode of the flag registers
	assign wr_supply_flag = wr_hit(reg_addr, ADDR_SUPPLY_FLAG, reg_wr);
	assign wr_regf_flag   = wr_hit(reg_addr, ADDR_REGFAULT_FLAG, reg_wr);
	assign wr_die_flag    = wr_hit(reg_addr, ADDR_DIE_FLAG, reg_wr);
	assign wr_conv_flag   = wr_hit(reg_addr, ADDR_CONV_FLAG, reg_wr);
	assign wr_pwrbtn_flag = wr_hit(reg_addr, ADDR_PWRBTN_FLAG, reg_wr);
	assign wr_pin_hi_flag = wr_hit(reg_addr, ADDR_PIN_HI_FLAG, reg_wr);
	assign wr_pin_lo_flag = wr_hit(reg_addr, ADDR_PIN_LO_FLAG, reg_wr);

	// Write-one clear terms
	assign supply_clr = wr_supply_flag & reg_wdata[0];
	assign regf_clr   = (wr_regf_flag & reg_wdata[0]) | cold_off_entry;
	assign die_clr    = wr_die_flag & reg_wdata[0];
	assign conv_clr   = wr_conv_flag ? reg_wdata[3:0] : 4'h0;
	assign pwrbtn_clr = wr_pwrbtn_flag & reg_wdata[0];
	assign pin_clr    = {(wr_pin_hi_flag ? reg_wdata[PIN_HI_W-1:0] : 7'h00),
		(wr_pin_lo_flag ? reg_wdata : RST_BYTE_ZERO)};

	// Set terms, masked at level two
	assign supply_set = supply_out_of_range & ~st_ff.supply_mask;
	assign regf_set   = regulator_fault & ~st_ff.regf_mask;
	assign die_set    = die_temp_alert & ~st_ff.die_mask;
	assign conv_set   = conv_event & ~st_ff.conv_mask;
	assign pin_set    = pin_edge & ~st_ff.pin_mask;

	always_comb begin
		conv_event = '0;
		conv_event[CONV_CH0]  = voltage_alert[0];
		conv_event[CONV_CH1]  = voltage_alert[1];
		conv_event[CONV_CH2]  = voltage_alert[2];
		conv_event[CONV_DONE] = conv_complete & st_ff.notify_armed;
	end

	// Group roll-up of unmasked flags
	always_comb begin
		group_any = '0;
		group_any[BIT_REGULATOR] = st_ff.regf_flag;
		group_any[BIT_PIN_EVENT] = |st_ff.pin_flag;
		group_any[BIT_CONVERTER] = st_ff.supply_flag | (|st_ff.conv_flag);
		group_any[BIT_THERMAL]   = st_ff.die_flag;
	end

	assign group_status = group_any & ~st_ff.group_mask & GROUP_BITS;
	assign irq_out      = |group_status;
	assign reg_rdata    = st_ff.rdata;
	assign pin_level    = pin_in;

	// Read mux
	always_comb begin
		case (reg_addr)
			ADDR_GROUP_STATUS:  rd_mux = group_status;
			ADDR_GROUP_MASK:    rd_mux = st_ff.group_mask;
			ADDR_SUPPLY_FLAG:   rd_mux = {7'h00, st_ff.supply_flag};
			ADDR_REGFAULT_FLAG: rd_mux = {7'h00, st_ff.regf_flag};
			ADDR_DIE_FLAG:      rd_mux = {7'h00, st_ff.die_flag};
			ADDR_CONV_FLAG:     rd_mux = {4'h0, st_ff.conv_flag};
			ADDR_PWRBTN_FLAG:   rd_mux = {7'h00, st_ff.pwrbtn_flag};
			ADDR_PIN_HI_FLAG:   rd_mux = {1'b0, st_ff.pin_flag[NUM_PINS-1:PIN_LO_W]};
			ADDR_PIN_LO_FLAG:   rd_mux = st_ff.pin_flag[PIN_LO_W-1:0];
			ADDR_SUPPLY_MASK:   rd_mux = {7'h00, st_ff.supply_mask};
			ADDR_REGFAULT_MASK: rd_mux = {7'h00, st_ff.regf_mask};
			ADDR_DIE_MASK:      rd_mux = {7'h00, st_ff.die_mask};
			ADDR_CONV_MASK:     rd_mux = {4'h0, st_ff.conv_mask};
			ADDR_PIN_HI_MASK:   rd_mux = {1'b0, st_ff.pin_mask[NUM_PINS-1:PIN_LO_W]};
			ADDR_PIN_LO_MASK:   rd_mux = st_ff.pin_mask[PIN_LO_W-1:0];
			default:            rd_mux = RST_BYTE_ZERO;
		endcase
	end

	always_comb begin
		nxt_st = st_ff;
		nxt_st.pin_prev = pin_in;
		if (reg_rd) begin
			nxt_st.rdata = rd_mux;
		end
		// Flag update: set wins over write-one clear
		nxt_st.pin_flag  = (st_ff.pin_flag & ~pin_clr) | pin_set;
		nxt_st.conv_flag = (st_ff.conv_flag & ~conv_clr) | conv_set;
		if (supply_set) begin
			nxt_st.supply_flag = 1'b1;
		end else if (supply_clr) begin
			nxt_st.supply_flag = 1'b0;
		end
		if (regf_set) begin
			nxt_st.regf_flag = 1'b1;
		end else if (regf_clr) begin
			nxt_st.regf_flag = 1'b0;
		end
		if (die_set) begin
			nxt_st.die_flag = 1'b1;
		end else if (die_clr) begin
			nxt_st.die_flag = 1'b0;
		end
		if (power_button_event) begin
			nxt_st.pwrbtn_flag = 1'b1;
		end else if (pwrbtn_clr) begin
			nxt_st.pwrbtn_flag = 1'b0;
		end
		// Notify choice captured when the request is issued
		if (conv_request) begin
			nxt_st.notify_armed = conv_request_notify;
		end else if (conv_complete) begin
			nxt_st.notify_armed = 1'b0;
		end
		// Mask registers
		if (wr_hit(reg_addr, ADDR_GROUP_MASK, reg_wr)) begin
			nxt_st.group_mask = reg_wdata & GROUP_BITS;
		end
		if (wr_hit(reg_addr, ADDR_SUPPLY_MASK, reg_wr)) begin
			nxt_st.supply_mask = reg_wdata[0];
		end
		if (wr_hit(reg_addr, ADDR_REGFAULT_MASK, reg_wr)) begin
			nxt_st.regf_mask = reg_wdata[0];
		end
		if (wr_hit(reg_addr, ADDR_DIE_MASK, reg_wr)) begin
			nxt_st.die_mask = reg_wdata[0];
		end
		if (wr_hit(reg_addr, ADDR_CONV_MASK, reg_wr)) begin
			nxt_st.conv_mask = reg_wdata[3:0];
		end
		if (wr_hit(reg_addr, ADDR_PIN_HI_MASK, reg_wr)) begin
			nxt_st.pin_mask[NUM_PINS-1:PIN_LO_W] = reg_wdata[PIN_HI_W-1:0];
		end
		if (wr_hit(reg_addr, ADDR_PIN_LO_MASK, reg_wr)) begin
			nxt_st.pin_mask[PIN_LO_W-1:0] = reg_wdata;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			st_ff              <= '0;
			st_ff.pin_mask     <= RST_PIN_MASK;
			st_ff.supply_mask  <= RST_BIT_MASKED;
			st_ff.regf_mask    <= RST_BIT_MASKED;
			st_ff.die_mask     <= RST_BIT_MASKED;
			st_ff.conv_mask    <= RST_CONV_MASK;
			st_ff.group_mask   <= RST_GROUP_MASK;
		end else begin
			st_ff <= nxt_st;
		end
	end
endmodule
`default_nettype wire

// >>> dv/tli_host_model.sv
// Host side register access model
`timescale 1ns/1ps
`default_nettype none
module tli_host_model (
	input  wire logic       clk_sys,
	input  wire logic [7:0] reg_rdata,
	output logic      [7:0] reg_addr,
	output logic      [7:0] reg_wdata,
	output logic            reg_wr,
	output logic            reg_rd
);
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		reg_wdata <= ~d;
		@(posedge clk_sys);
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(posedge clk_sys);
		d = reg_rdata;
	endtask
endmodule
`default_nettype wire

// >>> dv/tli_irq_tree_sva.sv
// Port checker for the interrupt tree
`timescale 1ns/1ps
`default_nettype none
module tli_irq_tree_sva
	import tli_pkg::*;
(
	input wire logic                         clk_sys,
	input wire logic                         reset_n,
	input wire logic [tli_pkg::ADDR_W-1:0]   reg_addr,
	input wire logic [tli_pkg::DATA_W-1:0]   reg_wdata,
	input wire logic                         reg_wr,
	input wire logic                         reg_rd,
	input wire logic [tli_pkg::DATA_W-1:0]   reg_rdata,
	input wire logic                         supply_out_of_range,
	input wire logic                         regulator_fault,
	input wire logic                         cold_off_entry,
	input wire logic                         die_temp_alert,
	input wire logic [2:0]                   voltage_alert,
	input wire logic                         conv_complete,
	input wire logic [tli_pkg::NUM_PINS-1:0] pin_in,
	input wire logic [tli_pkg::NUM_PINS-1:0] pin_level,
	input wire logic                         irq_out
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	logic quiet;
	assign quiet = !supply_out_of_range && !regulator_fault && !die_temp_alert && !cold_off_entry
		&& voltage_alert == 3'h0 && !conv_complete;
	sequence s_calm; quiet && $stable(pin_in) && $past(pin_in, 2) == pin_in; endsequence
	sequence s_mask_wr; reg_wr && reg_addr == ADDR_GROUP_MASK; endsequence
	sequence s_mask_rd; reg_rd && reg_addr == ADDR_GROUP_MASK; endsequence
	property p_mask_rw; s_mask_wr ##2 s_mask_rd |=> reg_rdata == ($past(reg_wdata, 3) & GROUP_BITS); endproperty
	a_mask_rw: assert property (p_mask_rw) else $error("group mask readback wrong");
	property p_status_rsvd; reg_rd && reg_addr == ADDR_GROUP_STATUS |=> (reg_rdata & ~GROUP_BITS) == 8'h00; endproperty
	a_status_rsvd: assert property (p_status_rsvd) else $error("reserved status bit set");
	property p_rd_unmapped; reg_rd && reg_addr > 8'h1a |=> reg_rdata == 8'h00; endproperty
	a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
	property p_rd_hold; !reg_rd |=> $stable(reg_rdata); endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
	property p_pin_level; pin_level == pin_in; endproperty
	a_pin_level: assert property (p_pin_level) else $error("pin level differs");
	property p_irq_status;
		s_calm ##0 (reg_rd && !reg_wr && reg_addr == ADDR_GROUP_STATUS) |=> irq_out == (reg_rdata != 8'h00);
	endproperty
	a_irq_status: assert property (p_irq_status) else $error("irq and status disagree");
	property p_wr_status; s_calm ##0 (reg_wr && reg_addr == ADDR_GROUP_STATUS) |=> $stable(irq_out); endproperty
	a_wr_status: assert property (p_wr_status) else $error("status write moved irq");
	property p_quiet_hold; s_calm ##0 !reg_wr |=> $stable(irq_out); endproperty
	a_quiet_hold: assert property (p_quiet_hold) else $error("irq moved without cause");
	property p_irq_rise; $rose(irq_out) |-> $past(!quiet || reg_wr) || ($past(pin_in) != $past(pin_in, 2)); endproperty
	a_irq_rise: assert property (p_irq_rise) else $error("irq rose without event");
endmodule
`default_nettype wire
bind tli_irq_tree tli_irq_tree_sva tli_irq_tree_sva_inst (.clk_sys, .reset_n, .reg_addr, .reg_wdata, .reg_wr,
	.reg_rd, .reg_rdata, .supply_out_of_range, .regulator_fault, .cold_off_entry, .die_temp_alert,
	.voltage_alert, .conv_complete, .pin_in, .pin_level, .irq_out);

// >>> dv/tb_top.sv
// Self-checking bench of the interrupt tree
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import tli_pkg::*;
	logic        clk_sys, reset_n, reg_wr, reg_rd, irq_out, crq, cnt;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata, d;
	logic [9:0]  ev;
	logic [14:0] pin_level, pin_dir;
	logic [29:0] esel;
	int          error_cnt, comparisons;
	logic [7:0]  fa [8] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h07, 8'h07, 8'h0c, 8'h08};
	logic [7:0]  fv [8] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h02, 8'h04, 8'h08, 8'h01};
	logic [7:0]  gb [8] = '{8'h08, 8'h40, 8'h02, 8'h08, 8'h08, 8'h08, 8'h20, 8'h00};
	logic [7:0]  ma [6] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h19, 8'h1a};
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	tli_host_model tli_host_model_inst (.clk_sys, .reg_rdata, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);
	tli_irq_tree tli_irq_tree_inst (.clk_sys, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.supply_out_of_range(ev[0]), .regulator_fault(ev[1]), .cold_off_entry(ev[9]), .die_temp_alert(ev[2]),
		.voltage_alert(ev[5:3]), .conv_request(crq), .conv_request_notify(cnt), .conv_complete(ev[8]),
		.power_button_event(ev[7]), .pin_in({11'h000, ev[6], 3'h0}), .pin_is_input(pin_dir),
		.edge_select_field(esel), .pin_level, .irq_out);
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		comparisons++;
		if (s !== e) begin
			error_cnt++;
			$display("[FAIL] %0t seen %h want %h", $time, s, e);
		end
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		tli_host_model_inst.rd(a, d);
		chk(d, e);
	endtask
	task automatic w(input logic [7:0] a, input logic [7:0] v);
		tli_host_model_inst.wr(a, v);
	endtask
	task automatic pulse(input int i);
		ev[i] <= 1'b1;
		@(posedge clk_sys);
		ev[i] <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk_sys);
		error_cnt++;
		final_report();
	end
	initial begin
		reset_n = 1'b0;
		ev = 10'h000;
		crq = 1'b0;
		cnt = 1'b0;
		pin_dir = 15'h7fff;
		esel = 30'h0000_0040;
		repeat (5) @(posedge clk_sys);
		reset_n <= 1'b1;
		@(posedge clk_sys);
		rc(ADDR_GROUP_STATUS, 8'h00);
		rc(ADDR_GROUP_MASK, 8'h6a);
		rc(8'h30, 8'h00);
		w(ADDR_GROUP_MASK, 8'hff);
		rc(ADDR_GROUP_MASK, 8'h6a);
		pulse(2);
		rc(ADDR_DIE_FLAG, 8'h00);
		$display("test reset_and_masks done");
		foreach (ma[k]) w(ma[k], 8'h00);
		w(ADDR_GROUP_MASK, 8'h00);
		for (int i = 0; i < 8; i++) begin
			pulse(i);
			rc(fa[i], fv[i]);
			rc(ADDR_GROUP_STATUS, gb[i]);
			chk({7'h00, irq_out}, {7'h00, gb[i] != 8'h00});
			w(fa[i], 8'h00);
			rc(fa[i], fv[i]);
			w(ADDR_GROUP_STATUS, 8'hff);
			rc(ADDR_GROUP_STATUS, gb[i]);
			w(fa[i], fv[i]);
			rc(ADDR_GROUP_STATUS, 8'h00);
			chk({7'h00, irq_out}, 8'h00);
		end
		esel <= 30'h0000_0080;
		pulse(6);
		rc(ADDR_PIN_LO_FLAG, 8'h08);
		w(ADDR_PIN_LO_FLAG, 8'h08);
		pin_dir <= 15'h7ff7;
		ev[6] <= 1'b1;
		@(posedge clk_sys);
		chk(pin_level[7:0], 8'h08);
		ev[6] <= 1'b0;
		@(posedge clk_sys);
		@(posedge clk_sys);
		rc(ADDR_PIN_LO_FLAG, 8'h00);
		$display("test event_sources done");
		w(ADDR_GROUP_MASK, 8'h02);
		pulse(2);
		rc(ADDR_GROUP_STATUS, 8'h00);
		chk({7'h00, irq_out}, 8'h00);
		w(ADDR_GROUP_MASK, 8'h00);
		rc(ADDR_GROUP_STATUS, 8'h02);
		chk({7'h00, irq_out}, 8'h01);
		pulse(1);
		pulse(9);
		rc(ADDR_REGFAULT_FLAG, 8'h00);
		w(ADDR_DIE_FLAG, 8'h01);
		crq <= 1'b1;
		@(posedge clk_sys);
		crq <= 1'b0;
		pulse(8);
		rc(ADDR_CONV_FLAG, 8'h00);
		crq <= 1'b1;
		cnt <= 1'b1;
		@(posedge clk_sys);
		crq <= 1'b0;
		pulse(8);
		rc(ADDR_CONV_FLAG, 8'h08);
		rc(ADDR_GROUP_STATUS, 8'h08);
		$display("test group_mask_cold_off_conversion done");
		final_report();
	end
endmodule
`default_nettype wire
